// >>> sdcc_map.svh
// Bit positions, codes and reset values of the serial DAC control block.
// Assumes a 16-bit serial word, MSB first.
`ifndef SDCC_MAP_SVH
`define SDCC_MAP_SVH
// ----------------------------------------------------------------
// Serial word layout
// ----------------------------------------------------------------
`define SDCC_WORD_BITS    16
`define SDCC_FINE_SEL_BIT 15
`define SDCC_ROUTE_LO_BIT 14
`define SDCC_ROUTE_HI_BIT 13
`define SDCC_ADDR_MSB     12
`define SDCC_ADDR_LSB     10
`define SDCC_MAIN_MSB     9
`define SDCC_MAIN_LSB     0
`define SDCC_FINE_MSB     9
`define SDCC_FINE_LSB     2
// ----------------------------------------------------------------
// System control bits
// ----------------------------------------------------------------
`define SDCC_CODING_BIT   6
`define SDCC_POWER_BIT    5
`define SDCC_GSLEEP_BIT   4
`define SDCC_SCLEAR_BIT   3
// ----------------------------------------------------------------
// Channel control bits
// ----------------------------------------------------------------
`define SDCC_BIAS_HI_BIT  9
`define SDCC_BIAS_LO_BIT  8
`define SDCC_SLEEP_N_BIT  4
`define SDCC_ZERO_BIT     3
// ----------------------------------------------------------------
// Reset values and clear codes
// ----------------------------------------------------------------
`define SDCC_RST_POWER    1'b1
`define SDCC_RST_GSLEEP   1'b1
`define SDCC_RST_SLEEP_N  1'b1
`define SDCC_RST_ZERO     1'b1
`define SDCC_RST_BIAS     2'h0
`define SDCC_CLR_TWOS     10'h000
`define SDCC_CLR_BIN      10'h000
`define SDCC_RST_MAIN     10'h000
`define SDCC_RST_FINE     8'h00
`endif

// >>> sdcc_pkg.sv
// Types shared by the serial DAC channel control block.
// Assumes sdcc_map.svh is on the include path.
package sdcc_pkg;
  // Register route selected by the two mode bits
  typedef enum logic [1:0] {
    SDCC_RT_SYS  = 2'b00,
    SDCC_RT_CHAN = 2'b01,
    SDCC_RT_DATA = 2'b10
  } sdcc_route_t;
  typedef struct packed {
    logic       sleep_n;
    logic       zeroing;
    logic [1:0] bias_src;
  } sdcc_chan_ctrl_t;
  typedef struct packed {
    logic power_active;
    logic global_sleep;
    logic coding_select;
    logic sys_clear;
  } sdcc_sys_ctrl_t;
endpackage : sdcc_pkg

// >>> sdcc_top.sv
// Control logic of a serially loaded multi-channel 10-bit DAC.
// Assumes a host driving frame sync, serial clock and data, plus load strobe.
`include "sdcc_map.svh"
module sdcc_top import sdcc_pkg::*; #(
  parameter int NUM_CH = 8
) (
  input  wire logic                   clk_in,
  input  wire logic                   sys_rst_in,
  input  wire logic                   serial_clock_in,
  input  wire logic                   frame_sync_n_in,
  input  wire logic                   serial_in,
  input  wire logic                   load_outputs_n_in,
  output sdcc_sys_ctrl_t              sys_ctrl_out,
  output sdcc_chan_ctrl_t [NUM_CH-1:0] chan_ctrl_out,
  output logic [NUM_CH-1:0]           chan_active_out,
  output logic [NUM_CH-1:0][9:0]      dac_main_out,
  output logic [NUM_CH-1:0][7:0]      dac_fine_out
);
  localparam int AW = $clog2(NUM_CH);

  // Only the quad and octal address decodes exist
  if (NUM_CH != 4 && NUM_CH != 8) begin : g_bad_num_ch
    $error("NUM_CH must be 4 or 8");
  end

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  // Channel decode
  function automatic logic [AW-1:0] chan_of(input logic [15:0] w);
    logic [2:0] a;
    a = w[`SDCC_ADDR_MSB:`SDCC_ADDR_LSB];
    chan_of = a[AW-1:0];
  endfunction : chan_of

  function automatic sdcc_route_t route_of(input logic [15:0] w);
    if (w[`SDCC_ROUTE_HI_BIT]) begin
      route_of = SDCC_RT_DATA;
    end else if (w[`SDCC_ROUTE_LO_BIT]) begin
      route_of = SDCC_RT_CHAN;
    end else begin
      route_of = SDCC_RT_SYS;
    end
  endfunction : route_of

  // ----------------------------------------------------------------
  // Serial link domain
  // ----------------------------------------------------------------
  // Frame sync high holds the bit counter cleared, so a short frame
  // leaves nothing behind even though the link clock stops.
  logic        frame_rst;
  logic [4:0]  bit_cnt_q, bit_cnt_d;
  logic [15:0] shift_q, shift_d;
  logic [15:0] word_q, word_d;
  logic        word_tog_q, word_tog_d;

  assign frame_rst = sys_rst_in | frame_sync_n_in;

  always_comb begin
    bit_cnt_d  = bit_cnt_q;
    shift_d    = shift_q;
    word_d     = word_q;
    word_tog_d = word_tog_q;
    if (bit_cnt_q < 5'(`SDCC_WORD_BITS)) begin
      shift_d   = {shift_q[14:0], serial_in};
      bit_cnt_d = bit_cnt_q + 5'h01;
    end
    if (bit_cnt_q == 5'(`SDCC_WORD_BITS - 1)) begin
      word_d     = {shift_q[14:0], serial_in};
      word_tog_d = ~word_tog_q;
    end
  end

  always_ff @(negedge serial_clock_in or posedge frame_rst) begin
    if (frame_rst) begin
      bit_cnt_q <= 5'h00;
      shift_q   <= 16'h0000;
    end else begin
      bit_cnt_q <= bit_cnt_d;
      shift_q   <= shift_d;
    end
  end

  always_ff @(negedge serial_clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      word_q     <= 16'h0000;
      word_tog_q <= 1'b0;
    end else begin
      word_q     <= word_d;
      word_tog_q <= word_tog_d;
    end
  end

  // ----------------------------------------------------------------
  // Crossings into the system clock
  // ----------------------------------------------------------------
  // The word register is stable for many system cycles after the
  // toggle, so it is read only once the toggle has been synchronised.
  logic [2:0] tog_sync_q, tog_sync_d;
  logic [2:0] ld_sync_q, ld_sync_d;
  logic       word_ev;
  logic       load_ev;
  logic [1:0] rst_sync_q, rst_sync_d;
  logic       core_rst;

  // Reset asserts at once but leaves on a clock edge, so that no
  // flop of this domain sees its release close to an edge.
  always_comb begin
    rst_sync_d = {rst_sync_q[0], 1'b0};
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rst_sync_q <= 2'h3;
    end else begin
      rst_sync_q <= rst_sync_d;
    end
  end

  assign core_rst = rst_sync_q[1];

  always_comb begin
    tog_sync_d = {tog_sync_q[1:0], word_tog_q};
    ld_sync_d  = {ld_sync_q[1:0], load_outputs_n_in};
  end

  always_ff @(posedge clk_in or posedge core_rst) begin
    if (core_rst) begin
      tog_sync_q <= 3'h0;
      ld_sync_q  <= 3'h7;
    end else begin
      tog_sync_q <= tog_sync_d;
      ld_sync_q  <= ld_sync_d;
    end
  end

  assign word_ev = tog_sync_q[2] ^ tog_sync_q[1];
  assign load_ev = ld_sync_q[2] & ~ld_sync_q[1];

  // ----------------------------------------------------------------
  // Register file and output registers
  // ----------------------------------------------------------------
  sdcc_sys_ctrl_t              sys_q, sys_d;
  sdcc_chan_ctrl_t [NUM_CH-1:0] ch_q, ch_d;
  logic [NUM_CH-1:0][9:0]      main_q, main_d;
  logic [NUM_CH-1:0][7:0]      fine_q, fine_d;
  logic [NUM_CH-1:0][9:0]      dmain_q, dmain_d;
  logic [NUM_CH-1:0][7:0]      dfine_q, dfine_d;
  logic [NUM_CH-1:0]           act_q, act_d;
  logic [9:0]                  clr_code;
  logic [AW-1:0]               sel;
  sdcc_route_t                 rt;

  assign clr_code = sys_q.coding_select ? `SDCC_CLR_BIN : `SDCC_CLR_TWOS;
  assign sel      = chan_of(word_q);
  assign rt       = route_of(word_q);

  always_comb begin
    sys_d   = sys_q;
    ch_d    = ch_q;
    main_d  = main_q;
    fine_d  = fine_q;
    if (word_ev) begin
      case (rt)
        SDCC_RT_SYS: begin
          sys_d.coding_select = word_q[`SDCC_CODING_BIT];
          sys_d.power_active  = word_q[`SDCC_POWER_BIT];
          sys_d.global_sleep  = word_q[`SDCC_GSLEEP_BIT];
          sys_d.sys_clear     = word_q[`SDCC_SCLEAR_BIT];
        end
        SDCC_RT_CHAN: begin
          ch_d[sel].sleep_n  = word_q[`SDCC_SLEEP_N_BIT];
          ch_d[sel].zeroing  = word_q[`SDCC_ZERO_BIT];
          ch_d[sel].bias_src = {word_q[`SDCC_BIAS_HI_BIT], word_q[`SDCC_BIAS_LO_BIT]};
        end
        SDCC_RT_DATA: begin
          if (word_q[`SDCC_FINE_SEL_BIT]) begin
            fine_d[sel] = word_q[`SDCC_FINE_MSB:`SDCC_FINE_LSB];
          end else begin
            main_d[sel] = word_q[`SDCC_MAIN_MSB:`SDCC_MAIN_LSB];
          end
        end
        default: begin
          sys_d = sys_q;
        end
      endcase
    end
  end

  always_comb begin
    dmain_d = dmain_q;
    dfine_d = dfine_q;
    if (load_ev) begin
      for (int i = 0; i < NUM_CH; i++) begin
        dmain_d[i] = (ch_q[i].zeroing || sys_q.sys_clear) ? clr_code : main_q[i];
        // Fine code passes in main coding
        dfine_d[i] = fine_q[i];
      end
    end
  end

  // Channel runs only when powered, not globally asleep, and awake
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      act_d[i] = sys_q.power_active & ~sys_q.global_sleep & ch_q[i].sleep_n;
    end
  end

  always_ff @(posedge clk_in or posedge core_rst) begin
    if (core_rst) begin
      sys_q.power_active  <= `SDCC_RST_POWER;
      sys_q.global_sleep  <= `SDCC_RST_GSLEEP;
      sys_q.coding_select <= 1'b0;
      sys_q.sys_clear     <= 1'b0;
      for (int i = 0; i < NUM_CH; i++) begin
        ch_q[i].sleep_n  <= `SDCC_RST_SLEEP_N;
        ch_q[i].zeroing  <= `SDCC_RST_ZERO;
        ch_q[i].bias_src <= `SDCC_RST_BIAS;
        main_q[i]        <= `SDCC_RST_MAIN;
        fine_q[i]        <= `SDCC_RST_FINE;
      end
    end else begin
      sys_q  <= sys_d;
      ch_q   <= ch_d;
      main_q <= main_d;
      fine_q <= fine_d;
    end
  end

  // DAC registers stay apart from the data registers, so a write
  // shows at the outputs only after the next load strobe.
  always_ff @(posedge clk_in or posedge core_rst) begin
    if (core_rst) begin
      for (int i = 0; i < NUM_CH; i++) begin
        dmain_q[i] <= `SDCC_RST_MAIN;
        dfine_q[i] <= `SDCC_RST_FINE;
      end
    end else begin
      dmain_q <= dmain_d;
      dfine_q <= dfine_d;
    end
  end

  // Activity follows the control registers one cycle later
  always_ff @(posedge clk_in or posedge core_rst) begin
    if (core_rst) begin
      act_q <= '0;
    end else begin
      act_q <= act_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from flops
  // ----------------------------------------------------------------
  assign sys_ctrl_out    = sys_q;
  assign chan_ctrl_out   = ch_q;
  assign chan_active_out = act_q;
  assign dac_main_out    = dmain_q;
  assign dac_fine_out    = dfine_q;
endmodule : sdcc_top

// >>> sdcc_host_model.sv
// Host model: frames 16-bit words onto the serial link.
// Assumes the bench calls send; the load strobe is driven elsewhere.
module sdcc_host_model (
  output logic serial_clock_out,
  output logic frame_sync_n_out,
  output logic serial_data_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------
  // Link driver
  // ----------------
  initial begin
    serial_clock_out = 1'b1;
    frame_sync_n_out = 1'b1;
    serial_data_out  = 1'b0;
  end
  task automatic send(input logic [15:0] w, input int n);
    #1.3 frame_sync_n_out = 1'b0;
    for (int i = 15; i > 15 - n; i--) begin
      serial_data_out = w[i];
      #24 serial_clock_out = 1'b0;
      #24 serial_clock_out = 1'b1;
    end
    frame_sync_n_out = 1'b1;
    // Released line flips so no stale bit can pass for data
    serial_data_out = ~serial_data_out;
  endtask : send
endmodule : sdcc_host_model

// >>> sdcc_top_properties.sv
// Port checker for the serial DAC control block.
// Assumes it is bound to sdcc_top and sees only its ports.
module sdcc_top_properties import sdcc_pkg::*; #(
  parameter int NUM_CH = 8
) (
  input wire logic                         clk_in,
  input wire logic                         sys_rst_in,
  input wire logic                         serial_clock_in,
  input wire logic                         frame_sync_n_in,
  input wire logic                         serial_in,
  input wire logic                         load_outputs_n_in,
  input wire sdcc_sys_ctrl_t               sys_ctrl_out,
  input wire sdcc_chan_ctrl_t [NUM_CH-1:0] chan_ctrl_out,
  input wire logic [NUM_CH-1:0]            chan_active_out,
  input wire logic [NUM_CH-1:0][9:0]       dac_main_out,
  input wire logic [NUM_CH-1:0][7:0]       dac_fine_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------
  // Helpers
  // ----------------
  logic [3:0]        idle_q, idle_d;
  logic [NUM_CH-1:0] awake;
  // Frame sync is async, so a few cycles of slack are allowed
  always_comb begin
    idle_d = idle_q + {3'h0, idle_q != 4'hF};
    if (!frame_sync_n_in) idle_d = 4'h0;
    for (int i = 0; i < NUM_CH; i++) awake[i] = chan_ctrl_out[i].sleep_n;
  end
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) idle_q <= 4'hF;
    else idle_q <= idle_d;
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  property p_sys_rst; $fell(sys_rst_in) |-> sys_ctrl_out[3:2] == 2'h3; endproperty
  a_sys_rst: assert property (p_sys_rst) else $error("sys reset value");
  property p_ch_rst; $fell(sys_rst_in) |-> chan_ctrl_out == {NUM_CH{4'hC}}; endproperty
  a_ch_rst: assert property (p_ch_rst) else $error("chan reset value");
  property p_main_ld; !$stable(dac_main_out) |-> !$past(load_outputs_n_in, 3)
    || !$past(load_outputs_n_in, 4); endproperty
  a_main_ld: assert property (p_main_ld) else $error("main moved");
  property p_fine_ld; !$stable(dac_fine_out) |-> !$past(load_outputs_n_in, 3)
    || !$past(load_outputs_n_in, 4); endproperty
  a_fine_ld: assert property (p_fine_ld) else $error("fine moved");
  property p_held; (!load_outputs_n_in) [*8] |-> $stable(dac_main_out); endproperty
  a_held: assert property (p_held) else $error("reload");
  property p_active; chan_active_out ==
    $past({NUM_CH{sys_ctrl_out[3] && !sys_ctrl_out[2]}} & awake); endproperty
  a_active: assert property (p_active) else $error("active");
  property p_ch_frm; !$stable(chan_ctrl_out) |-> idle_q < 4'hA; endproperty
  a_ch_frm: assert property (p_ch_frm) else $error("chan no frame");
  property p_sys_frm; !$stable(sys_ctrl_out) |-> idle_q < 4'hA; endproperty
  a_sys_frm: assert property (p_sys_frm) else $error("sys no frame");
  c_load: cover property ($fell(load_outputs_n_in));
  c_wake: cover property ($rose(chan_active_out[0]));
  c_clear: cover property (chan_ctrl_out[0].zeroing ##4 !$stable(dac_main_out[0]));
endmodule : sdcc_top_properties
bind sdcc_top sdcc_top_properties #(.NUM_CH(NUM_CH)) sdcc_top_properties_i (
  .clk_in(clk_in), .sys_rst_in(sys_rst_in), .serial_clock_in(serial_clock_in),
  .frame_sync_n_in(frame_sync_n_in), .serial_in(serial_in),
  .load_outputs_n_in(load_outputs_n_in), .sys_ctrl_out(sys_ctrl_out),
  .chan_ctrl_out(chan_ctrl_out), .chan_active_out(chan_active_out),
  .dac_main_out(dac_main_out), .dac_fine_out(dac_fine_out));

// >>> sdcc_top_tb_top.sv
// Bench: octal and quad builds fed by one host model.
// Assumes the host model frames words; reset and load come from here.
module sdcc_top_tb_top import sdcc_pkg::*; ;
  timeunit 1ns;
  timeprecision 100ps;
  logic                  clk_in, sys_rst_in, load_n, sclk, fsync_n, sdata;
  sdcc_sys_ctrl_t        sys_o;
  sdcc_chan_ctrl_t [7:0] ctrl_o;
  sdcc_chan_ctrl_t [3:0] q_ctrl;
  logic [7:0]            act_o;
  logic [7:0][9:0]       main_o;
  logic [7:0][7:0]       fine_o;
  int                    miscompares, checks_done;
  // ----------------
  // Clock and parts
  // ----------------
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  sdcc_host_model sdcc_host_model_i (.serial_clock_out(sclk), .frame_sync_n_out(fsync_n),
    .serial_data_out(sdata));
  sdcc_top #(.NUM_CH(8)) sdcc_top_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .serial_clock_in(sclk), .frame_sync_n_in(fsync_n), .serial_in(sdata),
    .load_outputs_n_in(load_n), .sys_ctrl_out(sys_o), .chan_ctrl_out(ctrl_o),
    .chan_active_out(act_o), .dac_main_out(main_o), .dac_fine_out(fine_o));
  sdcc_top #(.NUM_CH(4)) sdcc_top_q_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .serial_clock_in(sclk), .frame_sync_n_in(fsync_n), .serial_in(sdata),
    .load_outputs_n_in(load_n), .sys_ctrl_out(), .chan_ctrl_out(q_ctrl),
    .chan_active_out(), .dac_main_out(), .dac_fine_out());
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [15:0] w);
    sdcc_host_model_i.send(w, 16);
    repeat (10) @(posedge clk_in);
    #1;
  endtask : wr
  // Held low long enough to show that a level does not reload
  task automatic load;
    @(posedge clk_in) #1 load_n = 1'b0;
    repeat (10) @(posedge clk_in);
    #1 load_n = 1'b1;
    repeat (6) @(posedge clk_in);
    #1;
  endtask : load
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude
  initial begin
    repeat (100000) @(posedge clk_in);
    miscompares++;
    conclude();
  end
  // ----------------
  // Scenarios
  // ----------------
  initial begin
    sys_rst_in = 1'b1;
    load_n = 1'b1;
    miscompares = 0;
    checks_done = 0;
    repeat (10) @(posedge clk_in);
    #1 sys_rst_in = 1'b0;
    @(posedge clk_in) #1;
    chk(16'(sys_o[3:2]), 16'h0003);
    for (int i = 0; i < 8; i++) chk(16'(ctrl_o[i]), 16'h000C);
    chk(16'(act_o), 16'h0000);
    wr(16'h0060);
    chk(16'(sys_o), 16'h000A);
    chk(16'(act_o), 16'h00FF);
    for (int c = 0; c < 8; c++) begin
      int b;
      b = (c + c / 4) % 4;
      wr(16'h4010 | 16'(c << 10) | 16'(b << 8));
      chk(16'(ctrl_o[c]), 16'(8 | b));
      chk(16'(q_ctrl[c % 4]), 16'(8 | b));
    end
    sdcc_host_model_i.send(16'h4C00, 12);
    wr(16'h4800);
    chk(16'(ctrl_o[3]), 16'h000B);
    chk(16'(act_o), 16'h00FB);
    wr(16'h2200);
    wr(16'hA3FF);
    wr(16'h3FFF);
    chk(16'(main_o[0]), 16'h0000);
    load;
    chk(16'(main_o[0]), 16'h0200);
    chk(16'(fine_o[0]), 16'h00FF);
    chk(16'(main_o[7]), 16'h03FF);
    wr(16'h4018);
    chk(16'(main_o[0]), 16'h0200);
    load;
    chk(16'(main_o[0]), 16'h0000);
    chk(16'(fine_o[0]), 16'h00FF);
    wr(16'h4010);
    load;
    chk(16'(main_o[0]), 16'h0200);
    wr(16'h0068);
    chk(16'(sys_o), 16'h000B);
    load;
    chk(16'(main_o[7]), 16'h0000);
    chk(16'(fine_o[0]), 16'h00FF);
    wr(16'h0020);
    chk(16'(sys_o), 16'h0008);
    load;
    chk(16'(main_o[7]), 16'h03FF);
    conclude();
  end
endmodule : sdcc_top_tb_top
